// ===== hdl/dpioc_pkg.sv
// Purpose: constants for the two-pin general-purpose I/O control block
// Assumes: one 16-bit control register at one address of the control port
// Notes: bit positions are those of the pin control register
package dpioc_pkg;
  localparam int DPIOC_ADDR_W = 8;
  localparam int DPIOC_DATA_W = 16;
  localparam logic [7:0] PIN_IO_CONTROL_ADDR = 8'h23;
  localparam logic [15:0] PIN_IO_CONTROL_RST = 16'h0000;
  localparam int PIN_B_OUTPUT_ENABLE_BIT = 15;
  localparam int PIN_B_OUTPUT_LEVEL_BIT = 14;
  localparam int PIN_B_INPUT_ENABLE_BIT = 13;
  localparam int PIN_B_INPUT_FLAG_BIT = 12;
  localparam int PIN_A_OUTPUT_ENABLE_BIT = 11;
  localparam int PIN_A_OUTPUT_LEVEL_BIT = 10;
  localparam int PIN_A_INPUT_ENABLE_BIT = 9;
  localparam int PIN_A_INPUT_FLAG_BIT = 8;
  localparam int SYNC_STAGES = 2;
endpackage : dpioc_pkg

// ===== hdl/dpioc_sync.sv
// Purpose: two-flop synchroniser, one per pin
// Assumes: single core clock, synchronous active-high reset
// Notes: first stage is read only by the second stage
module dpioc_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // ==========================================================
  // two stages per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_comb
      begin
        meta_nxt[gi] = async_in[gi];
        sync_nxt[gi] = meta_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (clk_en_in)
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : dpioc_sync

// ===== hdl/dpioc_top.sv
// Purpose: control register and pin muxing for two multipurpose pins
// Assumes: register port is the decoded control-port access, synchronous to core clock
// Notes: pin outputs are muxed combinationally from registered control bits

// Notes on behaviour
// - pin b output-enable bit set, with input-enable clear, makes pin b a general-purpose output
// - pin b driven high or low per its output-level bit
// - pin b input-enable set makes it an input; no longer driven
// - pin b input flag reads pin level; meaningful only when input-enabled
// - pin a output-enable bit set, with input-enable clear, makes pin a a general-purpose output
// - pin a driven high or low per its output-level bit
// - pin a input-enable set makes it a general-purpose input
// - pin a input flag reads pin level; meaningful only when input-enabled
// - low byte reserved: reads zero; host writes zeros only
// - pin b alternate use acts only with both its enables clear
// - pin a alternate use acts only with both its enables clear
module dpioc_top (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [dpioc_pkg::DPIOC_ADDR_W-1:0] reg_addr_in,
  input wire logic [dpioc_pkg::DPIOC_DATA_W-1:0] reg_wdata_in,
  output logic [dpioc_pkg::DPIOC_DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // alternate functions from elsewhere
  input wire logic alt_a_data_in,
  input wire logic alt_a_oe_in,
  input wire logic alt_b_data_in,
  input wire logic alt_b_oe_in,
  output logic alt_a_active_out,
  output logic alt_b_active_out,
  // multipurpose pin a
  input wire logic multipurpose_pin_a_in,
  output logic multipurpose_pin_a_out,
  output logic multipurpose_pin_a_oe_out,
  // multipurpose pin b
  input wire logic multipurpose_pin_b_in,
  output logic multipurpose_pin_b_out,
  output logic multipurpose_pin_b_oe_out
);
  import dpioc_pkg::*;

  // ==========================================================
  // control bits
  logic pin_a_output_enable_r, pin_a_output_enable_nxt;
  logic pin_a_output_level_r, pin_a_output_level_nxt;
  logic pin_a_input_enable_r, pin_a_input_enable_nxt;
  logic pin_b_output_enable_r, pin_b_output_enable_nxt;
  logic pin_b_output_level_r, pin_b_output_level_nxt;
  logic pin_b_input_enable_r, pin_b_input_enable_nxt;
  logic pin_a_input_flag_r, pin_a_input_flag_nxt;
  logic pin_b_input_flag_r, pin_b_input_flag_nxt;
  logic [DPIOC_DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] pin_sync;
  logic hit;
  logic [DPIOC_DATA_W-1:0] reg_view;

  assign hit = (reg_addr_in == PIN_IO_CONTROL_ADDR);

  // ==========================================================
  // pin synchroniser
  dpioc_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .async_in({multipurpose_pin_b_in, multipurpose_pin_a_in}),
    .sync_out(pin_sync)
  );

  // ==========================================================
  // register view; reserved low byte forced to zero
  always_comb
  begin
    reg_view = '0;
    reg_view[PIN_B_OUTPUT_ENABLE_BIT] = pin_b_output_enable_r;
    reg_view[PIN_B_OUTPUT_LEVEL_BIT] = pin_b_output_level_r;
    reg_view[PIN_B_INPUT_ENABLE_BIT] = pin_b_input_enable_r;
    reg_view[PIN_B_INPUT_FLAG_BIT] = pin_b_input_flag_r;
    reg_view[PIN_A_OUTPUT_ENABLE_BIT] = pin_a_output_enable_r;
    reg_view[PIN_A_OUTPUT_LEVEL_BIT] = pin_a_output_level_r;
    reg_view[PIN_A_INPUT_ENABLE_BIT] = pin_a_input_enable_r;
    reg_view[PIN_A_INPUT_FLAG_BIT] = pin_a_input_flag_r;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    pin_a_output_enable_nxt = pin_a_output_enable_r;
    pin_a_output_level_nxt = pin_a_output_level_r;
    pin_a_input_enable_nxt = pin_a_input_enable_r;
    pin_b_output_enable_nxt = pin_b_output_enable_r;
    pin_b_output_level_nxt = pin_b_output_level_r;
    pin_b_input_enable_nxt = pin_b_input_enable_r;
    if (reg_wr_in && hit)
    begin
      // flag bits and low byte are read-only, write data there is dropped
      pin_b_output_enable_nxt = reg_wdata_in[PIN_B_OUTPUT_ENABLE_BIT];
      pin_b_output_level_nxt = reg_wdata_in[PIN_B_OUTPUT_LEVEL_BIT];
      pin_b_input_enable_nxt = reg_wdata_in[PIN_B_INPUT_ENABLE_BIT];
      pin_a_output_enable_nxt = reg_wdata_in[PIN_A_OUTPUT_ENABLE_BIT];
      pin_a_output_level_nxt = reg_wdata_in[PIN_A_OUTPUT_LEVEL_BIT];
      pin_a_input_enable_nxt = reg_wdata_in[PIN_A_INPUT_ENABLE_BIT];
    end
    // flag follows the pin only while input-enabled, else reads zero
    pin_a_input_flag_nxt = pin_a_input_enable_r & pin_sync[0];
    pin_b_input_flag_nxt = pin_b_input_enable_r & pin_sync[1];
    rvalid_nxt = reg_rd_in;
    rdata_nxt = (reg_rd_in && hit) ? reg_view : '0;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      pin_a_output_enable_r <= PIN_IO_CONTROL_RST[PIN_A_OUTPUT_ENABLE_BIT];
      pin_a_output_level_r <= PIN_IO_CONTROL_RST[PIN_A_OUTPUT_LEVEL_BIT];
      pin_a_input_enable_r <= PIN_IO_CONTROL_RST[PIN_A_INPUT_ENABLE_BIT];
      pin_b_output_enable_r <= PIN_IO_CONTROL_RST[PIN_B_OUTPUT_ENABLE_BIT];
      pin_b_output_level_r <= PIN_IO_CONTROL_RST[PIN_B_OUTPUT_LEVEL_BIT];
      pin_b_input_enable_r <= PIN_IO_CONTROL_RST[PIN_B_INPUT_ENABLE_BIT];
      pin_a_input_flag_r <= PIN_IO_CONTROL_RST[PIN_A_INPUT_FLAG_BIT];
      pin_b_input_flag_r <= PIN_IO_CONTROL_RST[PIN_B_INPUT_FLAG_BIT];
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pin_a_output_enable_r <= pin_a_output_enable_nxt;
      pin_a_output_level_r <= pin_a_output_level_nxt;
      pin_a_input_enable_r <= pin_a_input_enable_nxt;
      pin_b_output_enable_r <= pin_b_output_enable_nxt;
      pin_b_output_level_r <= pin_b_output_level_nxt;
      pin_b_input_enable_r <= pin_b_input_enable_nxt;
      pin_a_input_flag_r <= pin_a_input_flag_nxt;
      pin_b_input_flag_r <= pin_b_input_flag_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  // ==========================================================
  // pin muxing
  // input-enable wins over output-enable so a pin is never fought over
  always_comb
  begin
    alt_a_active_out = ~pin_a_output_enable_r & ~pin_a_input_enable_r;
    alt_b_active_out = ~pin_b_output_enable_r & ~pin_b_input_enable_r;
    multipurpose_pin_a_oe_out = 1'b0;
    multipurpose_pin_a_out = 1'b0;
    multipurpose_pin_b_oe_out = 1'b0;
    multipurpose_pin_b_out = 1'b0;
    if (pin_a_output_enable_r && !pin_a_input_enable_r)
    begin
      multipurpose_pin_a_oe_out = 1'b1;
      multipurpose_pin_a_out = pin_a_output_level_r;
    end
    else if (alt_a_active_out)
    begin
      multipurpose_pin_a_oe_out = alt_a_oe_in;
      multipurpose_pin_a_out = alt_a_data_in;
    end
    if (pin_b_output_enable_r && !pin_b_input_enable_r)
    begin
      multipurpose_pin_b_oe_out = 1'b1;
      multipurpose_pin_b_out = pin_b_output_level_r;
    end
    else if (alt_b_active_out)
    begin
      multipurpose_pin_b_oe_out = alt_b_oe_in;
      multipurpose_pin_b_out = alt_b_data_in;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  b_out_drive_a: assert property (pin_b_output_enable_r && !pin_b_input_enable_r
    |-> multipurpose_pin_b_oe_out && multipurpose_pin_b_out == pin_b_output_level_r)
    else $error("pin b not driven at its level");
  b_level_write_a: assert property (clk_en_in && reg_wr_in && hit
    && !reg_wdata_in[PIN_B_INPUT_ENABLE_BIT] && reg_wdata_in[PIN_B_OUTPUT_ENABLE_BIT]
    |=> multipurpose_pin_b_oe_out
    && multipurpose_pin_b_out == $past(reg_wdata_in[PIN_B_OUTPUT_LEVEL_BIT]))
    else $error("pin b level not taken from write");
  b_input_quiet_a: assert property (pin_b_input_enable_r
    |-> !multipurpose_pin_b_oe_out && !alt_b_active_out)
    else $error("pin b driven while input");
  b_flag_track_a: assert property ((clk_en_in && pin_b_input_enable_r
    && $stable(multipurpose_pin_b_in)) [*4]
    |-> pin_b_input_flag_r == multipurpose_pin_b_in)
    else $error("pin b flag lags pin");
  a_out_drive_a: assert property (pin_a_output_enable_r && !pin_a_input_enable_r
    |-> multipurpose_pin_a_oe_out && multipurpose_pin_a_out == pin_a_output_level_r)
    else $error("pin a not driven at its level");
  a_level_write_a: assert property (clk_en_in && reg_wr_in && hit
    |=> pin_a_output_level_r == $past(reg_wdata_in[PIN_A_OUTPUT_LEVEL_BIT]))
    else $error("pin a level bit not written");
  a_input_quiet_a: assert property (pin_a_input_enable_r
    |-> !multipurpose_pin_a_oe_out && !alt_a_active_out)
    else $error("pin a driven while input");
  a_flag_track_a: assert property ((clk_en_in && pin_a_input_enable_r
    && $stable(multipurpose_pin_a_in)) [*4]
    |-> pin_a_input_flag_r == multipurpose_pin_a_in)
    else $error("pin a flag lags pin");
  rsvd_zero_a: assert property (reg_rvalid_out |-> reg_rdata_out[7:0] == 8'h00)
    else $error("reserved bits not zero");
  alt_b_gate_a: assert property (alt_b_active_out
    |-> multipurpose_pin_b_oe_out == alt_b_oe_in && multipurpose_pin_b_out == alt_b_data_in)
    else $error("pin b alternate not passed");
  alt_a_gate_a: assert property (alt_a_active_out
    |-> multipurpose_pin_a_oe_out == alt_a_oe_in && multipurpose_pin_a_out == alt_a_data_in)
    else $error("pin a alternate not passed");
  flag_sync_delay_a: assert property (clk_en_in [*3] ##1 $rose(pin_a_input_flag_r)
    |-> $past(multipurpose_pin_a_in, 3))
    else $error("pin a flag bypassed synchroniser");

  b_output_c: cover property (multipurpose_pin_b_oe_out && multipurpose_pin_b_out);
  a_input_c: cover property (pin_a_input_flag_r);
  read_hit_c: cover property (reg_rvalid_out && reg_rdata_out != 16'h0000);
  alt_a_c: cover property (alt_a_active_out && alt_a_oe_in);
endmodule : dpioc_top

// ===== verif/dpioc_pin_model.sv
// Purpose: outside world wired to the two multipurpose pins
// Assumes: both pins carry a pull-up
// Notes: device drive wins; contention is not modelled
module dpioc_pin_model (
  // device side
  input wire logic a_oe_in,
  input wire logic a_drv_in,
  input wire logic b_oe_in,
  input wire logic b_drv_in,
  // outside drivers
  input wire logic a_ext_en_in,
  input wire logic a_ext_in,
  input wire logic b_ext_en_in,
  input wire logic b_ext_in,
  // resolved wires
  output logic a_wire_out,
  output logic b_wire_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin floats to the pull-up, never holds its last value
  assign a_wire_out = a_oe_in ? a_drv_in : (a_ext_en_in ? a_ext_in : 1'h1);
  assign b_wire_out = b_oe_in ? b_drv_in : (b_ext_en_in ? b_ext_in : 1'h1);
endmodule : dpioc_pin_model

// ===== verif/dpioc_top_tb.sv
// Purpose: register and pin checks for the two-pin control block
// Assumes: 20 MHz core clock, synchronous reset
// Notes: pin levels judged on the resolved wires
module dpioc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dpioc_pkg::*;
  // ==========================================
  // stimulus and wires
  logic core_clk_in = 1'h0, srst_in = 1'h1, clk_en_in = 1'h1;
  logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, reg_rvalid_out;
  logic [DPIOC_ADDR_W-1:0] reg_addr_in = '0;
  logic [DPIOC_DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out;
  logic alt_a_data_in = 1'h0, alt_a_oe_in = 1'h0, alt_b_data_in = 1'h0, alt_b_oe_in = 1'h0;
  logic alt_a_active_out, alt_b_active_out, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic a_ext_en = 1'h0, a_ext = 1'h0, b_ext_en = 1'h0, b_ext = 1'h0;
  int failures = 0, n_checks = 0, cycles = 0;
  always #25 core_clk_in = ~core_clk_in;
  dpioc_top u_dpioc_top (.core_clk_in(core_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .alt_a_data_in(alt_a_data_in), .alt_a_oe_in(alt_a_oe_in), .alt_b_data_in(alt_b_data_in),
    .alt_b_oe_in(alt_b_oe_in), .alt_a_active_out(alt_a_active_out),
    .alt_b_active_out(alt_b_active_out), .multipurpose_pin_a_in(pa_in),
    .multipurpose_pin_a_out(pa_out), .multipurpose_pin_a_oe_out(pa_oe),
    .multipurpose_pin_b_in(pb_in), .multipurpose_pin_b_out(pb_out),
    .multipurpose_pin_b_oe_out(pb_oe));
  dpioc_pin_model u_dpioc_pin_model (.a_oe_in(pa_oe), .a_drv_in(pa_out), .b_oe_in(pb_oe),
    .b_drv_in(pb_out), .a_ext_en_in(a_ext_en), .a_ext_in(a_ext), .b_ext_en_in(b_ext_en),
    .b_ext_in(b_ext), .a_wire_out(pa_in), .b_wire_out(pb_in));
  // ==========================================
  // access and compare tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(posedge core_clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= addr;
    reg_wdata_in <= data;
    @(posedge core_clk_in);
    reg_wr_in <= 1'h0;
    #1;
  endtask : wr
  // answer is registered on the taking edge itself, so no wait loop needed
  task automatic rchk(input logic [7:0] addr, input logic [15:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= addr;
    @(posedge core_clk_in);
    reg_rd_in <= 1'h0;
    #1;
    chk(reg_rvalid_out, 16'h0001);
    chk(reg_rdata_out, exp);
  endtask : rchk
  // order: alt b, alt a, oe b, oe a, wire b, wire a
  task automatic pins(input logic [5:0] exp);
    chk({alt_b_active_out, alt_a_active_out, pb_oe, pa_oe, pb_in, pa_in}, exp);
  endtask : pins
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      summarize();
    end
  end
  // ==========================================
  // test sequence
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    srst_in <= 1'h0;
    rchk(8'h23, 16'h0000);
    pins(6'h33);
    wr(8'h23, 16'hD000);
    pins(6'h1B);
    rchk(8'h23, 16'hC000);
    wr(8'h23, 16'h8000);
    pins(6'h19);
    wr(8'h23, 16'h0C00);
    pins(6'h27);
    wr(8'h23, 16'h0800);
    pins(6'h26);
    @(posedge core_clk_in);
    b_ext_en <= 1'h1;
    wr(8'h23, 16'hA000);
    pins(6'h11);
    @(posedge core_clk_in);
    b_ext <= 1'h1;
    rchk(8'h23, 16'hA000);
    rchk(8'h23, 16'hB000);
    @(posedge core_clk_in);
    b_ext <= 1'h0;
    repeat (4) @(posedge core_clk_in);
    rchk(8'h23, 16'hA000);
    @(posedge core_clk_in);
    b_ext_en <= 1'h0;
    a_ext_en <= 1'h1;
    a_ext <= 1'h1;
    wr(8'h23, 16'h0200);
    pins(6'h23);
    repeat (4) @(posedge core_clk_in);
    rchk(8'h23, 16'h0300);
    wr(8'h23, 16'h0000);
    rchk(8'h23, 16'h0000);
    @(posedge core_clk_in);
    a_ext_en <= 1'h0;
    alt_a_oe_in <= 1'h1;
    alt_b_oe_in <= 1'h1;
    alt_b_data_in <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    #1;
    pins(6'h3E);
    wr(8'h23, 16'h2000);
    pins(6'h16);
    wr(8'h23, 16'h0200);
    pins(6'h2B);
    wr(8'h23, 16'h0800);
    pins(6'h2E);
    wr(8'h22, 16'hFFFF);
    rchk(8'h24, 16'h0000);
    @(posedge core_clk_in);
    clk_en_in <= 1'h0;
    wr(8'h23, 16'hC000);
    @(posedge core_clk_in);
    clk_en_in <= 1'h1;
    rchk(8'h23, 16'h0800);
    // mid-run reset must clear every control bit again
    @(posedge core_clk_in);
    srst_in <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'h0;
    rchk(8'h23, 16'h0000);
    pins(6'h3E);
    summarize();
  end
endmodule : dpioc_top_tb
